// >>> rtl/bte_exec.sv
// Execution unit for branches, bit and flag operations, moves, loads, stores and program reads
// Summary of operation
// - Overflow clear branch: pc plus offset plus one, flags kept, 1 or 2 cycles.
// - Branches on interrupt enable set or clear, same target, 1 or 2 cycles.
// - I/O bit set and clear change only that bit, no flags, 2 cycles.
// - Rotate left takes carry into bit 0, old bit 7 to carry.
// - Rotate right takes carry into bit 7, old bit 0 to carry.
// - Arithmetic right shift keeps sign bit, updates Z C N V, one cycle.
// - Copy a register bit into the transfer flag only, one cycle.
// - Write transfer flag into a register bit, flags kept, one cycle.
// - Set and clear interrupt enable, only that flag, one cycle.
// - Each status flag set or clear alone, also by index, one cycle.
// - Byte copy, pair copy and constant load, one cycle, flags kept.
// - Pointer load, optional post increment of the pointer, two cycles.
// - Pre decrement load lowers pointer then reads at new value, two cycles.
// - Displacement load on second and third pointers, pointer kept, two cycles.
// - Absolute address load, two cycles, flags kept.
// - Pointer stores plain, post increment, pre decrement, two cycles.
// - Displacement store on second and third pointers, pointer kept, two cycles.
// - Absolute address store, two cycles, flags kept.
// - Program read at third pointer into a register, optional increment, three cycles.
// - Extended program read uses extension byte and pointer, optional increment of both, three cycles.
//
// The address map and the address-and-strobe port were decided locally.
`default_nettype none
module bte_exec
  import bte_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction issue
  input wire logic issue,
  input wire logic [4:0] op,
  input wire logic [4:0] rd_sel,
  input wire logic [4:0] rr_sel,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] imm,
  input wire logic [6:0] branch_offset,
  input wire logic [5:0] displacement,
  input wire logic [DADDR_W-1:0] abs_addr,
  input wire logic [5:0] io_sel,
  input wire logic [1:0] ptr_sel,
  input wire logic [1:0] ptr_mode,
  output logic ready,
  output logic retire,
  // Data memory, read data valid in the strobe cycle
  output logic [DADDR_W-1:0] dmem_addr,
  output logic dmem_re,
  output logic dmem_we,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata,
  // I/O register space, masked bit write
  output logic [5:0] io_addr,
  output logic io_we,
  output logic [7:0] io_wmask,
  output logic [7:0] io_wdata,
  // Program memory, read data valid the cycle after the strobe
  output logic [PADDR_W-1:0] pmem_addr,
  output logic pmem_re,
  input wire logic [7:0] pmem_rdata,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata
);

  // ==========================================================
  // State
  logic [7:0] rf [REG_COUNT];
  logic [7:0] flags;
  logic [7:0] ext;
  logic [PC_W-1:0] pc;
  bte_state_t state;
  logic [4:0] ld_dst;
  logic pm_inc;
  logic pm_ext;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] pair_read(input logic [4:0] idx);
    pair_read = {rf[{idx[4:1], 1'b1}], rf[{idx[4:1], 1'b0}]};
  endfunction

  function automatic logic [4:0] ptr_index(input logic [1:0] sel);
    ptr_index = PTR_BASE + {2'h0, sel, 1'b0};
  endfunction

  bte_op_t op_in;
  logic go;
  logic [7:0] rd_val;
  logic [7:0] rr_val;
  logic [15:0] ptr_val;
  logic [4:0] ptr_idx;
  logic host_wr;

  assign op_in = bte_op_t'(op);
  assign ready = (state == ST_IDLE);
  assign go = issue && ready;
  assign rd_val = rf[rd_sel];
  assign rr_val = rf[rr_sel];
  assign ptr_idx = ptr_index(ptr_sel);
  // A process, not a continuous assign, so that register file writes wake the pointer value
  always_comb begin
    ptr_val = pair_read(ptr_idx);
  end
  // Software may only write while the core is idle and not starting, so no write port collides
  assign host_wr = reg_we && ready && !issue;

  // ==========================================================
  // Next state
  bte_state_t next_state;
  logic [PC_W-1:0] next_pc;
  logic [7:0] next_flags;
  logic [7:0] next_ext;
  logic w_en;
  logic [4:0] w_idx;
  logic [7:0] w_data;
  logic p_en;
  logic [4:0] p_idx;
  logic [15:0] p_data;
  logic [DADDR_W-1:0] next_dmem_addr;
  logic next_dmem_re;
  logic next_dmem_we;
  logic [7:0] next_dmem_wdata;
  logic [4:0] next_ld_dst;
  logic next_io_we;
  logic [7:0] next_io_wmask;
  logic [7:0] next_io_wdata;
  logic [5:0] next_io_addr;
  logic [PADDR_W-1:0] next_pmem_addr;
  logic next_pmem_re;
  logic next_pm_inc;
  logic next_pm_ext;
  logic [7:0] sh_res;
  logic sh_c;
  logic [PC_W-1:0] br_target;
  logic [PADDR_W-1:0] pm_next;

  assign br_target = pc + {{(PC_W-7){branch_offset[6]}}, branch_offset} + PC_STEP_ONE;
  assign pm_next = pmem_addr + 24'h000001;

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_flags = flags;
    next_ext = ext;
    w_en = 1'b0;
    w_idx = rd_sel;
    w_data = 8'h00;
    p_en = 1'b0;
    p_idx = ptr_idx;
    p_data = 16'h0000;
    next_dmem_addr = dmem_addr;
    next_dmem_re = 1'b0;
    next_dmem_we = 1'b0;
    next_dmem_wdata = dmem_wdata;
    next_ld_dst = ld_dst;
    next_io_we = 1'b0;
    next_io_wmask = io_wmask;
    next_io_wdata = io_wdata;
    next_io_addr = io_addr;
    next_pmem_addr = pmem_addr;
    next_pmem_re = 1'b0;
    next_pm_inc = pm_inc;
    next_pm_ext = pm_ext;
    sh_res = 8'h00;
    sh_c = 1'b0;
    case (state)
      ST_IDLE: begin
        if (go) begin
          next_pc = pc + PC_STEP_ONE;
          case (op_in)
            OP_BRANCH_NO_OVERFLOW, OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
              if ((op_in == OP_BRANCH_NO_OVERFLOW && !flags[FLAG_V]) ||
                  (op_in == OP_BRANCH_IRQ_ON && flags[FLAG_I]) ||
                  (op_in == OP_BRANCH_IRQ_OFF && !flags[FLAG_I])) begin
                next_pc = br_target;
                next_state = ST_BRANCH;
              end
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              // Mask write lets the I/O space touch only the addressed bit
              next_io_we = 1'b1;
              next_io_addr = io_sel;
              next_io_wmask = 8'h01 << bit_sel;
              next_io_wdata = (op_in == OP_IO_BIT_SET) ? next_io_wmask : 8'h00;
              next_state = ST_ACCESS;
            end
            OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH: begin
              case (op_in)
                OP_SHIFT_LEFT_LOGICAL: {sh_c, sh_res} = {rd_val, 1'b0};
                OP_SHIFT_RIGHT_LOGICAL: {sh_res, sh_c} = {1'b0, rd_val};
                OP_ROTATE_LEFT_CARRY: {sh_c, sh_res} = {rd_val, flags[FLAG_C]};
                OP_ROTATE_RIGHT_CARRY: {sh_res, sh_c} = {flags[FLAG_C], rd_val};
                default: {sh_res, sh_c} = {rd_val[7], rd_val};
              endcase
              w_en = 1'b1;
              w_data = sh_res;
              next_flags[FLAG_C] = sh_c;
              next_flags[FLAG_Z] = (sh_res == 8'h00);
              next_flags[FLAG_N] = sh_res[7];
              next_flags[FLAG_V] = sh_res[7] ^ sh_c;
            end
            OP_SWAP_NIBBLES: begin
              w_en = 1'b1;
              w_data = {rd_val[3:0], rd_val[7:4]};
            end
            OP_BIT_TO_TRANSFER_FLAG: next_flags[FLAG_T] = rd_val[bit_sel];
            OP_TRANSFER_FLAG_TO_BIT: begin
              w_en = 1'b1;
              w_data = rd_val;
              w_data[bit_sel] = flags[FLAG_T];
            end
            // Dedicated set and clear of each flag, I included, are these with a fixed index
            OP_FLAG_SET_BY_INDEX: next_flags[bit_sel] = 1'b1;
            OP_FLAG_CLEAR_BY_INDEX: next_flags[bit_sel] = 1'b0;
            OP_REG_COPY_BYTE: begin
              w_en = 1'b1;
              w_data = rr_val;
            end
            OP_REG_COPY_PAIR: begin
              p_en = 1'b1;
              p_idx = rd_sel;
              p_data = pair_read(rr_sel);
            end
            OP_LOAD_CONSTANT: begin
              w_en = 1'b1;
              w_data = imm;
            end
            OP_LOAD_VIA_POINTER, OP_STORE_VIA_POINTER: begin
              next_dmem_addr = ptr_val;
              if (ptr_mode == PM_POST_INC) begin
                p_en = 1'b1;
                p_data = ptr_val + 16'h0001;
              end else if (ptr_mode == PM_PRE_DEC) begin
                p_en = 1'b1;
                p_data = ptr_val - 16'h0001;
                next_dmem_addr = p_data;
              end
            end
            OP_LOAD_POINTER_OFFSET, OP_STORE_POINTER_OFFSET: begin
              next_dmem_addr = ptr_val + {10'h000, displacement};
            end
            OP_LOAD_ABSOLUTE, OP_STORE_ABSOLUTE: begin
              next_pc = pc + PC_STEP_TWO;
              next_dmem_addr = abs_addr;
            end
            OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_EXT: begin
              next_pmem_addr = {(op_in == OP_PROGRAM_MEMORY_READ_EXT) ? ext : 8'h00,
                                pair_read(ptr_index(PTR_Z))};
              next_pmem_re = 1'b1;
              next_ld_dst = rd_sel;
              next_pm_inc = (ptr_mode == PM_POST_INC);
              next_pm_ext = (op_in == OP_PROGRAM_MEMORY_READ_EXT);
              next_state = ST_PROG_WAIT;
            end
            default: begin
            end
          endcase
          case (op_in)
            OP_LOAD_VIA_POINTER, OP_LOAD_POINTER_OFFSET, OP_LOAD_ABSOLUTE: begin
              next_dmem_re = 1'b1;
              next_ld_dst = rd_sel;
              next_state = ST_ACCESS;
            end
            OP_STORE_VIA_POINTER, OP_STORE_POINTER_OFFSET, OP_STORE_ABSOLUTE: begin
              // Source is sampled before any pointer update, so a store of a pointer byte sends its old value
              next_dmem_we = 1'b1;
              next_dmem_wdata = rr_val;
              next_state = ST_ACCESS;
            end
            default: begin
            end
          endcase
        end
      end
      ST_BRANCH: next_state = ST_IDLE;
      ST_ACCESS: begin
        if (dmem_re) begin
          w_en = 1'b1;
          w_idx = ld_dst;
          w_data = dmem_rdata;
        end
        next_state = ST_IDLE;
      end
      ST_PROG_WAIT: next_state = ST_PROG_DATA;
      ST_PROG_DATA: begin
        w_en = 1'b1;
        w_idx = ld_dst;
        w_data = pmem_rdata;
        if (pm_inc) begin
          p_en = 1'b1;
          p_idx = ptr_index(PTR_Z);
          p_data = pm_next[15:0];
          if (pm_ext) begin
            next_ext = pm_next[23:16];
          end
        end
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Register file; a byte write wins over a pair write to the same register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        rf[i] <= 8'h00;
      end
    end else begin
      if (p_en) begin
        rf[{p_idx[4:1], 1'b0}] <= p_data[7:0];
        rf[{p_idx[4:1], 1'b1}] <= p_data[15:8];
      end
      if (w_en) begin
        rf[w_idx] <= w_data;
      end
      if (host_wr && !reg_addr[5]) begin
        rf[reg_addr[4:0]] <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Flags, extension byte and program counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags <= FLAGS_RESET;
    end else if (host_wr && reg_addr == REG_ADDR_FLAGS) begin
      flags <= reg_wdata;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext <= EXT_RESET;
    end else if (host_wr && reg_addr == REG_ADDR_EXT) begin
      ext <= reg_wdata;
    end else begin
      ext <= next_ext;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc <= PC_RESET;
    end else if (host_wr && reg_addr == REG_ADDR_PC_LO) begin
      pc <= {pc[15:8], reg_wdata};
    end else if (host_wr && reg_addr == REG_ADDR_PC_HI) begin
      pc <= {reg_wdata, pc[7:0]};
    end else begin
      pc <= next_pc;
    end
  end

  // ==========================================================
  // Sequencer and memory side outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      retire <= 1'b0;
      ld_dst <= 5'h00;
      pm_inc <= 1'b0;
      pm_ext <= 1'b0;
    end else begin
      state <= next_state;
      retire <= (go || !ready) && next_state == ST_IDLE;
      ld_dst <= next_ld_dst;
      pm_inc <= next_pm_inc;
      pm_ext <= next_pm_ext;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dmem_addr <= 16'h0000;
      dmem_re <= 1'b0;
      dmem_we <= 1'b0;
      dmem_wdata <= 8'h00;
      io_addr <= 6'h00;
      io_we <= 1'b0;
      io_wmask <= 8'h00;
      io_wdata <= 8'h00;
      pmem_addr <= 24'h000000;
      pmem_re <= 1'b0;
    end else begin
      dmem_addr <= next_dmem_addr;
      dmem_re <= next_dmem_re;
      dmem_we <= next_dmem_we;
      dmem_wdata <= next_dmem_wdata;
      io_addr <= next_io_addr;
      io_we <= next_io_we;
      io_wmask <= next_io_wmask;
      io_wdata <= next_io_wdata;
      pmem_addr <= next_pmem_addr;
      pmem_re <= next_pmem_re;
    end
  end

  // ==========================================================
  // Register port read, data in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        REG_ADDR_FLAGS: reg_rdata <= flags;
        REG_ADDR_EXT: reg_rdata <= ext;
        REG_ADDR_PC_LO: reg_rdata <= pc[7:0];
        REG_ADDR_PC_HI: reg_rdata <= pc[15:8];
        default: reg_rdata <= reg_addr[5] ? 8'h00 : rf[reg_addr[4:0]];
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_start(bte_op_t o);
    go && op_in == o;
  endsequence
  sequence s_two_busy;
    !ready ##1 ready;
  endsequence

  a_vclear_branch_taken: assert property (s_start(OP_BRANCH_NO_OVERFLOW) ##0 !flags[FLAG_V] |=>
    pc == $past(br_target) && $stable(flags) ##0 s_two_busy) else $error("overflow branch timing wrong");
  a_irq_branch_fall: assert property (s_start(OP_BRANCH_IRQ_ON) ##0 !flags[FLAG_I] |=>
    ready && pc == $past(pc) + PC_STEP_ONE) else $error("untaken branch not one cycle");
  a_io_bit_write: assert property ((s_start(OP_IO_BIT_SET) or s_start(OP_IO_BIT_CLEAR)) |=>
    io_we && $onehot(io_wmask) && $stable(flags) ##0 s_two_busy) else $error("io bit op wrong");
  a_shift_flag_v: assert property (s_start(OP_ROTATE_LEFT_CARRY) |=>
    flags[FLAG_C] == $past(rd_val[7]) && flags[FLAG_V] == (flags[FLAG_N] ^ flags[FLAG_C]) && ready)
    else $error("rotate left flags wrong");
  a_asr_sign_kept: assert property (s_start(OP_SHIFT_RIGHT_ARITH) ##0 rd_sel != 5'h00 |=>
    rf[$past(rd_sel)][7] == $past(rd_val[7])) else $error("sign bit lost");
  a_transfer_flag: assert property (s_start(OP_BIT_TO_TRANSFER_FLAG) |=>
    flags[FLAG_T] == $past(rd_val[bit_sel]) && (flags & 8'hBF) == ($past(flags) & 8'hBF))
    else $error("transfer flag copy wrong");
  a_flag_index_set: assert property (s_start(OP_FLAG_SET_BY_INDEX) |=>
    flags[$past(bit_sel)] && ready) else $error("flag set by index wrong");
  a_move_no_flags: assert property (s_start(OP_REG_COPY_BYTE) |=>
    $stable(flags) && ready && retire) else $error("byte copy timing wrong");
  a_load_two_cycle: assert property (s_start(OP_LOAD_VIA_POINTER) |=>
    dmem_re ##0 s_two_busy) else $error("load not two cycles");
  a_predec_addr: assert property (s_start(OP_STORE_VIA_POINTER) ##0 ptr_mode == PM_PRE_DEC |=>
    dmem_we && dmem_addr == $past(ptr_val) - 16'h0001) else $error("pre decrement address wrong");
  a_prog_three: assert property (s_start(OP_PROGRAM_MEMORY_READ_EXT) |=>
    pmem_re && pmem_addr[23:16] == $past(ext) ##1 !ready ##1 ready) else $error("program read not three cycles");

endmodule // bte_exec
`default_nettype wire

// >>> rtl/bte_pkg.sv
// Package: constants, encodings and types of the bit and transfer execution unit
`default_nettype none
package bte_pkg;
  // ==========================================================
  // Widths
  localparam int REG_COUNT = 32;
  localparam int PC_W = 16;
  localparam int DADDR_W = 16;
  localparam int PADDR_W = 24;
  // ==========================================================
  // Flag positions within the status flags register
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  // ==========================================================
  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  // ==========================================================
  // Pointer pairs: low byte register index of the first pair, then the pair selectors
  localparam logic [4:0] PTR_BASE = 5'h1A;
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  // ==========================================================
  // Cycle counts per instruction
  localparam int CYC_SIMPLE = 1;
  localparam int CYC_BR_TAKEN = 2;
  localparam int CYC_IO_BIT = 2;
  localparam int CYC_DATA_MEM = 2;
  localparam int CYC_PROG_MEM = 3;
  // Program counter steps
  localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP_TWO = 16'h0002;
  // ==========================================================
  // Register port map
  localparam logic [5:0] REG_ADDR_FLAGS = 6'h20;
  localparam logic [5:0] REG_ADDR_EXT = 6'h21;
  localparam logic [5:0] REG_ADDR_PC_LO = 6'h22;
  localparam logic [5:0] REG_ADDR_PC_HI = 6'h23;
  // ==========================================================
  // Operations
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BRANCH_NO_OVERFLOW = 5'h01, OP_BRANCH_IRQ_ON = 5'h02,
    OP_BRANCH_IRQ_OFF = 5'h03, OP_IO_BIT_SET = 5'h04, OP_IO_BIT_CLEAR = 5'h05,
    OP_SHIFT_LEFT_LOGICAL = 5'h06, OP_SHIFT_RIGHT_LOGICAL = 5'h07, OP_ROTATE_LEFT_CARRY = 5'h08,
    OP_ROTATE_RIGHT_CARRY = 5'h09, OP_SHIFT_RIGHT_ARITH = 5'h0A, OP_SWAP_NIBBLES = 5'h0B,
    OP_BIT_TO_TRANSFER_FLAG = 5'h0C, OP_TRANSFER_FLAG_TO_BIT = 5'h0D,
    OP_FLAG_SET_BY_INDEX = 5'h0E, OP_FLAG_CLEAR_BY_INDEX = 5'h0F,
    OP_REG_COPY_BYTE = 5'h10, OP_REG_COPY_PAIR = 5'h11, OP_LOAD_CONSTANT = 5'h12,
    OP_LOAD_VIA_POINTER = 5'h13, OP_LOAD_POINTER_OFFSET = 5'h14, OP_LOAD_ABSOLUTE = 5'h15,
    OP_STORE_VIA_POINTER = 5'h16, OP_STORE_POINTER_OFFSET = 5'h17, OP_STORE_ABSOLUTE = 5'h18,
    OP_PROGRAM_MEMORY_READ = 5'h19, OP_PROGRAM_MEMORY_READ_EXT = 5'h1A
  } bte_op_t;
  typedef enum logic [1:0] {
    PM_PLAIN = 2'h0, PM_POST_INC = 2'h1, PM_PRE_DEC = 2'h2
  } bte_ptr_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_BRANCH = 3'h1, ST_ACCESS = 3'h2, ST_PROG_WAIT = 3'h3, ST_PROG_DATA = 3'h4
  } bte_state_t;
endpackage
`default_nettype wire

// >>> dv/bte_mem_model.sv
// Partner model: data memory, I/O register space and program memory
`default_nettype none
module bte_mem_model
  import bte_pkg::*;
(
  // Clock
  input wire logic clk,
  // Data memory
  input wire logic [DADDR_W-1:0] dmem_addr,
  input wire logic dmem_re,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata,
  // I/O space
  input wire logic [5:0] io_addr,
  input wire logic io_we,
  input wire logic [7:0] io_wmask,
  input wire logic [7:0] io_wdata,
  // Program memory
  input wire logic [PADDR_W-1:0] pmem_addr,
  input wire logic pmem_re,
  output logic [7:0] pmem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Storage, low address byte only: aliasing above 0xFF is a known limit
  logic [7:0] dmem [256];
  logic [7:0] io [64];
  logic [7:0] noise;
  logic pm_ok;
  logic [PADDR_W-1:0] pm_a;
  initial begin
    noise = 8'h00;
    pm_ok = 1'b0;
    pm_a = '0;
    for (int i = 0; i < 256; i++) dmem[i] = 8'(i) ^ 8'hA5;
    for (int i = 0; i < 64; i++) io[i] = 8'hF0;
  end
  // Idle read lines show a moving pattern so a stale value never passes
  assign dmem_rdata = dmem_re ? dmem[dmem_addr[7:0]] : noise;
  assign pmem_rdata = pm_ok ? (pm_a[7:0] ^ pm_a[15:8] ^ pm_a[23:16]) : ~noise;
  always @(posedge clk) begin
    noise <= noise + 8'h3B;
    pm_ok <= pmem_re;
    pm_a <= pmem_addr;
    if (dmem_we) dmem[dmem_addr[7:0]] <= dmem_wdata;
    if (io_we) io[io_addr] <= (io[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
  end
endmodule // bte_mem_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the execution unit
`default_nettype none
module testbench;
  import bte_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Stimulus and observation
  logic clk = 1'b0, reset = 1'b1, issue = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
  logic [4:0] op = '0, rd_sel = '0, rr_sel = '0;
  logic [2:0] bit_sel = '0;
  logic [7:0] imm = '0, reg_wdata = '0, reg_rdata, dmem_wdata, dmem_rdata, io_wmask, io_wdata, pmem_rdata;
  logic [6:0] branch_offset = '0;
  logic [5:0] displacement = '0, io_sel = '0, reg_addr = '0, io_addr;
  logic [15:0] abs_addr = '0, dmem_addr;
  logic [1:0] ptr_sel = '0, ptr_mode = '0;
  logic [23:0] pmem_addr;
  logic ready, retire, dmem_re, dmem_we, io_we, pmem_re;
  int fails = 0, n_tests = 0;
  bte_exec dut (.clk, .reset, .issue, .op, .rd_sel, .rr_sel, .bit_sel, .imm, .branch_offset, .displacement,
    .abs_addr, .io_sel, .ptr_sel, .ptr_mode, .ready, .retire, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata,
    .dmem_rdata, .io_addr, .io_we, .io_wmask, .io_wdata, .pmem_addr, .pmem_re, .pmem_rdata, .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata);
  bte_mem_model mem (.clk, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata, .dmem_rdata, .io_addr, .io_we,
    .io_wmask, .io_wdata, .pmem_addr, .pmem_re, .pmem_rdata);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask
  // Issue one instruction and count edges until retire; bounded wait
  task automatic go(input bte_op_t o, input int n);
    int k;
    @(posedge clk);
    op <= o;
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    k = 1;
    #1;
    while (retire !== 1'b1 && k < 9) begin
      @(posedge clk);
      #1 k++;
    end
    chk(16'(k), 16'(n));
    if (k == 9) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic t_moves();
    rd_sel <= 5'h10;
    imm <= 8'h81;
    go(OP_LOAD_CONSTANT, 1);
    rd_sel <= 5'h12;
    rr_sel <= 5'h10;
    go(OP_REG_COPY_PAIR, 1);
    rchk(6'h12, 8'h81);
  endtask
  task automatic t_shifts();
    bte_op_t ops [5] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH};
    logic [7:0] res [5] = '{8'h00, 8'h40, 8'h01, 8'hC0, 8'hC0};
    logic [7:0] fl [5] = '{8'h0B, 8'h00, 8'h09, 8'h0C, 8'h0C};
    rd_sel <= 5'h10;
    for (int i = 0; i < 5; i++) begin
      wr(6'h10, 8'h80);
      wr(REG_ADDR_FLAGS, 8'h01);
      go(ops[i], 1);
      rchk(6'h10, res[i]);
      rchk(REG_ADDR_FLAGS, fl[i]);
    end
  endtask
  task automatic t_flags();
    wr(REG_ADDR_FLAGS, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bit_sel <= 3'(i);
      go(OP_FLAG_SET_BY_INDEX, 1);
      rchk(REG_ADDR_FLAGS, 8'h01 << i);
      go(OP_FLAG_CLEAR_BY_INDEX, 1);
      rchk(REG_ADDR_FLAGS, 8'h00);
    end
    wr(6'h11, 8'h00);
    bit_sel <= 3'h7;
    go(OP_BIT_TO_TRANSFER_FLAG, 1);
    rchk(REG_ADDR_FLAGS, 8'h40);
    rd_sel <= 5'h11;
    bit_sel <= 3'h0;
    go(OP_TRANSFER_FLAG_TO_BIT, 1);
    rchk(6'h11, 8'h01);
    rchk(REG_ADDR_FLAGS, 8'h40);
  endtask
  task automatic t_branch();
    bte_op_t ops [6] = '{OP_BRANCH_NO_OVERFLOW, OP_BRANCH_NO_OVERFLOW, OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF,
      OP_BRANCH_IRQ_OFF, OP_BRANCH_IRQ_ON};
    logic [7:0] fl [6] = '{8'h00, 8'h08, 8'h80, 8'h80, 8'h00, 8'h00};
    logic [15:0] pc = 16'h0100;
    wr(REG_ADDR_PC_LO, 8'h00);
    wr(REG_ADDR_PC_HI, 8'h01);
    branch_offset <= 7'h7E;
    for (int i = 0; i < 6; i++) begin
      wr(REG_ADDR_FLAGS, fl[i]);
      go(ops[i], (i % 2 == 0) ? 2 : 1);
      pc = (i % 2 == 0) ? pc - 16'h0001 : pc + 16'h0001;
      rchk(REG_ADDR_PC_LO, pc[7:0]);
      rchk(REG_ADDR_PC_HI, pc[15:8]);
      rchk(REG_ADDR_FLAGS, fl[i]);
    end
  endtask
  task automatic t_io();
    io_sel <= 6'h05;
    bit_sel <= 3'h3;
    go(OP_IO_BIT_SET, 2);
    chk(16'(mem.io[5]), 16'h00F8);
    bit_sel <= 3'h5;
    go(OP_IO_BIT_CLEAR, 2);
    chk(16'(mem.io[5]), 16'h00D8);
  endtask
  task automatic t_data();
    wr(6'h1A, 8'h10);
    wr(6'h1B, 8'h00);
    rd_sel <= 5'h10;
    ptr_sel <= PTR_X;
    ptr_mode <= PM_POST_INC;
    go(OP_LOAD_VIA_POINTER, 2);
    rchk(6'h10, 8'hB5);
    rchk(6'h1A, 8'h11);
    ptr_mode <= PM_PRE_DEC;
    wr(6'h10, 8'h00);
    go(OP_LOAD_VIA_POINTER, 2);
    rchk(6'h10, 8'hB5);
    rchk(6'h1A, 8'h10);
    wr(6'h1C, 8'h20);
    wr(6'h1D, 8'h00);
    ptr_sel <= PTR_Y;
    displacement <= 6'h05;
    go(OP_LOAD_POINTER_OFFSET, 2);
    rchk(6'h10, 8'h80);
    rchk(6'h1C, 8'h20);
    abs_addr <= 16'h0030;
    go(OP_LOAD_ABSOLUTE, 2);
    rchk(6'h10, 8'h95);
    wr(6'h1E, 8'h40);
    wr(6'h1F, 8'h00);
    rr_sel <= 5'h10;
    ptr_sel <= PTR_Z;
    go(OP_STORE_VIA_POINTER, 2);
    chk(16'(mem.dmem[8'h3F]), 16'h0095);
    displacement <= 6'h02;
    go(OP_STORE_POINTER_OFFSET, 2);
    chk(16'(mem.dmem[8'h41]), 16'h0095);
    abs_addr <= 16'h0050;
    go(OP_STORE_ABSOLUTE, 2);
    chk(16'(mem.dmem[8'h50]), 16'h0095);
  endtask
  task automatic t_prog();
    wr(REG_ADDR_EXT, 8'h01);
    wr(6'h1E, 8'hFF);
    wr(6'h1F, 8'hFF);
    rd_sel <= 5'h05;
    ptr_mode <= PM_POST_INC;
    go(OP_PROGRAM_MEMORY_READ_EXT, 3);
    rchk(6'h05, 8'h01);
    rchk(6'h1F, 8'h00);
    rchk(REG_ADDR_EXT, 8'h02);
    wr(6'h00, 8'hEE);
    rd_sel <= 5'h00;
    ptr_mode <= PM_PLAIN;
    go(OP_PROGRAM_MEMORY_READ, 3);
    rchk(6'h00, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_moves();
    t_shifts();
    t_flags();
    t_branch();
    t_io();
    t_data();
    t_prog();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
